/* File: test/core_system_model.sv */
// Model of the core flag and of the system that receives special cycles
`timescale 1ns/1ps
`default_nettype none
module core_system_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Interrupt flag
  input  wire logic       if_clear_q,
  input  wire logic       set_if,
  output var  logic       if_flag,
  // Special cycles seen by the system
  input  wire logic       entry_cycle_q,
  input  wire logic       exit_cycle_q,
  input  wire logic       halt_cycle_q,
  output var  logic [7:0] entry_cnt_q,
  output var  logic [7:0] exit_cnt_q,
  output var  logic [7:0] halt_cnt_q
);
  // Flag cleared on entry, set by the handler
  always_ff @(posedge aclk) begin
    if (!aresetn) if_flag <= 1'h0;
    else if (if_clear_q) if_flag <= 1'h0;
    else if (set_if) if_flag <= 1'h1;
  end
  // Cycle counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      entry_cnt_q <= 8'h00;
      exit_cnt_q  <= 8'h00;
      halt_cnt_q  <= 8'h00;
    end else begin
      entry_cnt_q <= entry_cnt_q + 8'(entry_cycle_q);
      exit_cnt_q  <= exit_cnt_q + 8'(exit_cycle_q);
      halt_cnt_q  <= halt_cnt_q + 8'(halt_cycle_q);
    end
  end
endmodule : core_system_model
`default_nettype wire

/* File: test/smm_save_state_tb.sv */
// Self-checking bench for the save-state block
`timescale 1ns/1ps
`default_nettype none
module smm_save_state_tb
  import smm_save_pkg::*;
;
  localparam logic [15:0]       REV    = 16'h0042;  // Arbitrary value
  localparam logic [ADDR_W-1:0] A_HALT = 18'h3_fb24;
  localparam logic [ADDR_W-1:0] A_NMI  = 18'h3_fb28;
  localparam logic [ADDR_W-1:0] A_VIRT = 18'h3_fb60;
  localparam logic [ADDR_W-1:0] A_REV  = 18'h3_fbf0;
  localparam logic [ADDR_W-1:0] A_BASE = 18'h3_fc00;
  localparam logic [ADDR_W-1:0] A_CTRL = 18'h0_0000;
  localparam logic [ADDR_W-1:0] A_HB   = 18'h0_0004;
  localparam logic [ADDR_W-1:0] A_R0   = 18'h0_0008;
  localparam logic [ADDR_W-1:0] A_R1   = 18'h0_000c;
  localparam logic [ADDR_W-1:0] A_STAT = 18'h0_0010;
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, set_if, if_flag;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              smm_entry, resume_req, iret_done, addr_bit20_mask;
  logic              debug_request, stop_clock_request, exception_req;
  entry_state_t      entry_state;
  logic              in_smm_q, intr_block_q, nmi_block_q, smi_block_q, init_block_q;
  logic              addr20_force_q, if_clear_q, resume_halt_q, resume_fetch_q;
  logic              debug_take_q, stop_take_q, exception_take_q;
  logic              entry_cycle_q, exit_cycle_q, halt_cycle_q;
  logic [7:0]        entry_cnt_q, exit_cnt_q, halt_cnt_q;
  int                n_mismatch, tests_run;

  smm_save_state #(.BASE_RELOC_SUPPORTED(1'h1), .IO_TRAP_SUPPORTED(1'h0),
    .REVISION_NUMBER(REV)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .smm_entry, .entry_state, .resume_req, .iret_done, .if_flag,
    .addr_bit20_mask, .debug_request, .stop_clock_request, .exception_req, .in_smm_q,
    .intr_block_q, .nmi_block_q, .smi_block_q, .init_block_q, .addr20_force_q,
    .if_clear_q, .resume_halt_q, .resume_fetch_q, .debug_take_q, .stop_take_q,
    .exception_take_q, .entry_cycle_q, .exit_cycle_q, .halt_cycle_q);

  core_system_model sys (.aclk, .aresetn, .if_clear_q, .set_if, .if_flag, .entry_cycle_q,
    .exit_cycle_q, .halt_cycle_q, .entry_cnt_q, .exit_cnt_q, .halt_cnt_q);

  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid === 1'h1) && n < 50);
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'h0;
  endtask : axw

  task automatic axr(input logic [ADDR_W-1:0] a, input string nm, input logic [1:0] er,
                     input logic [31:0] ed);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid === 1'h1) && n < 50);
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk(nm, ed, rdata);
    rready <= 1'h0;
  endtask : axr

  // Core event pulse: 0 entry, 1 resume, 2 iret; ends mid-cycle after the taking edge
  task automatic ev(input int k, input logic [3:0] s);
    @(posedge aclk);
    smm_entry   <= (k == 0);
    resume_req  <= (k == 1);
    iret_done   <= (k == 2);
    entry_state <= s;
    @(posedge aclk);
    smm_entry  <= 1'h0;
    resume_req <= 1'h0;
    iret_done  <= 1'h0;
    @(negedge aclk);
  endtask : ev

  task automatic t_regs;
    axr(A_REV, "revision", RESP_OKAY, {14'h0, 1'h1, 1'h0, REV});
    axw(A_REV, 32'hffff_ffff, RESP_OKAY);
    axr(A_REV, "revision ro", RESP_OKAY, {14'h0, 1'h1, 1'h0, REV});
    axw(18'h0_0100, 32'h1234_5678, RESP_SLVERR);
    axr(18'h0_0100, "unmapped", RESP_SLVERR, 32'h0000_0000);
    axr(A_CTRL, "control", RESP_OKAY, 32'h0000_0000);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_halt;
    axw(A_HB, 32'h000a_0000, RESP_OKAY);
    @(posedge aclk);
    addr_bit20_mask    <= 1'h1;
    debug_request      <= 1'h1;
    stop_clock_request <= 1'h1;
    exception_req      <= 1'h1;
    set_if             <= 1'h1;
    @(posedge aclk);
    set_if <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("pre entry", 32'h3, {30'h0, if_flag, addr20_force_q});
    ev(0, 4'hf);
    chk("entry outs", 32'h7f, {25'h0, in_smm_q, smi_block_q, init_block_q, intr_block_q,
        nmi_block_q, if_clear_q, entry_cycle_q});
    repeat (2) @(posedge aclk);
    chk("mode levels", 32'h17, {26'h0, if_flag, intr_block_q, addr20_force_q, debug_take_q,
        stop_take_q, exception_take_q});
    @(posedge aclk);
    set_if <= 1'h1;
    @(posedge aclk);
    set_if <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("intr unblocked", 32'h0, {31'h0, intr_block_q});
    axr(A_HALT, "halt byte", RESP_OKAY, 32'h0000_0001);
    axr(A_NMI, "nmi byte", RESP_OKAY, 32'h0000_0001);
    axr(A_VIRT, "virt byte", RESP_OKAY, {24'h0, VIRT_NESTED});
    axr(A_BASE, "base copy", RESP_OKAY, 32'h000a_0000);
    ev(1, 4'h0);
    chk("halt resume", 32'h39, {26'h0, resume_halt_q, halt_cycle_q, exit_cycle_q,
        resume_fetch_q, in_smm_q, nmi_block_q});
    repeat (2) @(posedge aclk);
    chk("cycle counts", 32'h0001_0101, {8'h0, entry_cnt_q, exit_cnt_q, halt_cnt_q});
    $display("t_halt done");
  endtask : t_halt

  task automatic t_nmi;
    ev(0, 4'h0);
    chk("nmi blocked", 32'h1, {31'h0, nmi_block_q});
    axw(A_NMI, 32'hffff_ffff, RESP_OKAY);
    axr(A_NMI, "nmi rewrite", RESP_OKAY, 32'h0000_0001);
    axw(A_HALT, 32'hffff_ffff, RESP_OKAY);
    axr(A_HALT, "halt rewrite", RESP_OKAY, 32'h0000_0001);
    ev(2, 4'h0);
    chk("nmi after iret", 32'h0, {31'h0, nmi_block_q});
    axr(A_STAT, "status", RESP_OKAY, 32'h0000_0003);
    chk("nmi stays", 32'h0, {31'h0, nmi_block_q});
    ev(1, 4'h0);
    chk("sw halt resume", 32'h4, {29'h0, resume_halt_q, resume_fetch_q, nmi_block_q});
    $display("t_nmi done");
  endtask : t_nmi

  task automatic t_cyc;
    logic [3:0] st [3];
    logic [7:0] code [3];
    st   = '{4'h0, 4'h2, 4'h3};
    code = '{VIRT_HOST, VIRT_GUEST, VIRT_NESTED};
    axw(A_CTRL, 32'h0000_0001, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      if (i == 1) axw(A_CTRL, 32'h0000_0003, RESP_OKAY);
      ev(0, st[i]);
      chk("entry cycle off", 32'h0, {31'h0, entry_cycle_q});
      axr(A_VIRT, "virt code", RESP_OKAY, {24'h0, code[i]});
      axr(A_HALT, "halt clear", RESP_OKAY, 32'h0000_0000);
      ev(1, 4'h0);
      chk("fetch resume", {29'h0, 2'h2, i == 0}, {29'h0, resume_fetch_q, resume_halt_q,
          exit_cycle_q});
    end
    chk("cycle counts", 32'h0002_0302, {8'h0, entry_cnt_q, exit_cnt_q, halt_cnt_q});
    $display("t_cyc done");
  endtask : t_cyc

  task automatic t_lock;
    axw(A_R0, 32'h1111_0000, RESP_OKAY);
    axw(A_R1, 32'h2222_0000, RESP_OKAY);
    axw(A_CTRL, 32'h0000_0007, RESP_OKAY);
    axw(A_R0, 32'hdead_0000, RESP_OKAY);
    axw(A_R1, 32'hbeef_0000, RESP_OKAY);
    axr(A_R0, "range0", RESP_OKAY, 32'h1111_0000);
    axr(A_R1, "range1", RESP_OKAY, 32'h2222_0000);
    $display("t_lock done");
  endtask : t_lock

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, set_if} = 7'h00;
    {smm_entry, resume_req, iret_done, addr_bit20_mask} = 4'h0;
    {debug_request, stop_clock_request, exception_req} = 3'h0;
    {awaddr, araddr, wdata, wstrb, entry_state} = '0;
    n_mismatch = 0;
    tests_run  = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_halt();
    t_nmi();
    t_cyc();
    t_lock();
    conclude();
  end
endmodule : smm_save_state_tb
`default_nettype wire

/* File: verilog/axil_slave_port.sv */
// AXI4-Lite slave handshake front end
`timescale 1ns/1ps
`default_nettype none
module axil_slave_port
  import smm_save_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // Write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read address and data
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Register side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_hit,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_hit
);

  logic aw_have_q, w_have_q, ar_have_q;
  logic aw_have_d, w_have_d, ar_have_d, bvalid_d, rvalid_d;
  logic rd_fire;

  assign wr_en     = aw_have_q & w_have_q & ~bvalid;
  assign rd_fire   = ar_have_q & ~rvalid;
  assign aw_have_d = (aw_have_q & ~wr_en) | (awvalid & awready);
  assign w_have_d  = (w_have_q & ~wr_en) | (wvalid & wready);
  assign bvalid_d  = (bvalid & ~bready) | wr_en;
  assign ar_have_d = (ar_have_q & ~rd_fire) | (arvalid & arready);
  assign rvalid_d  = (rvalid & ~rready) | rd_fire;

  // Write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      wr_addr   <= '0;
      wr_data   <= WORD_RESET;
      wr_strb   <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready   <= ~aw_have_d & ~bvalid_d;
      wready    <= ~w_have_d & ~bvalid_d;
      bvalid    <= bvalid_d;
      if (awvalid && awready) begin
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_have_q <= 1'b0;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= WORD_RESET;
      rresp     <= RESP_OKAY;
      rd_addr   <= '0;
    end else begin
      ar_have_q <= ar_have_d;
      arready   <= ~ar_have_d & ~rvalid_d;
      rvalid    <= rvalid_d;
      if (arvalid && arready) begin
        rd_addr <= araddr;
      end
      if (rd_fire) begin
        rdata <= rd_hit ? rd_data : WORD_RESET;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule : axil_slave_port
`default_nettype wire

/* File: verilog/smm_save_pkg.sv */
// Constants, types and helpers shared by the save-state block
package smm_save_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_HALT_RESTART = 16'hfec9;
  localparam logic [15:0] IDX_NMI_RECORD   = 16'hfeca;
  localparam logic [15:0] IDX_VIRT_STATE   = 16'hfed8;
  localparam logic [15:0] IDX_REVISION     = 16'hfefc;
  localparam logic [15:0] IDX_BASE_COPY    = 16'hff00;
  localparam logic [15:0] IDX_CONTROL      = 16'h0000;
  localparam logic [15:0] IDX_HANDLER_BASE = 16'h0001;
  localparam logic [15:0] IDX_RANGE0       = 16'h0002;
  localparam logic [15:0] IDX_RANGE1       = 16'h0003;
  localparam logic [15:0] IDX_STATUS       = 16'h0004;

  localparam int ADDR_W = 18;

  // Field positions
  localparam int HALT_BIT       = 0;
  localparam int NMI_BIT        = 0;
  localparam int RELOC_BIT      = 17;
  localparam int IO_TRAP_BIT    = 16;
  localparam int CTRL_ENTRY_DIS = 0;
  localparam int CTRL_EXIT_DIS  = 1;
  localparam int CTRL_LOCK      = 2;
  localparam int STAT_IN_SMM    = 0;
  localparam int STAT_NMI_EN    = 1;

  // Virtualization state codes
  localparam logic [7:0] VIRT_HOST   = 8'h00;
  localparam logic [7:0] VIRT_GUEST  = 8'h02;
  localparam logic [7:0] VIRT_NESTED = 8'h06;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [2:0]  CTRL_RESET = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Core state sampled on entry
  typedef struct packed {
    logic halted;
    logic nmi_masked;
    logic guest;
    logic nested_paging;
  } entry_state_t;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

endpackage : smm_save_pkg

/* File: verilog/smm_save_state.sv */
// System management save-state, masking and special cycle control
// Function
// - Entry records halt state in halt bit
// - Resume goes to halt or saved instruction
// - Halt resume: no refetch, broadcast halt cycle
// - Entry records NMI masking; software may rewrite
// - Entry stores read-only virtualization state code
// - Read-only revision word with feature bits
// - Entry copies handler base into save area
// - Entry masks INTR, NMI, SMI, INIT, bit-20 mask
// - Entry clears IF; handler sets it
// - Address bit 20 never forced low inside
// - NMI recognised right after IRET inside
// - NMI stays enabled; exit restores prior masking
// - Debug, stop-clock and exceptions still answered
// - Entry and exit cycles, each separately disabled
// - Lock bit freezes both protected-range registers
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module smm_save_state
  import smm_save_pkg::*;
#(
  parameter logic        BASE_RELOC_SUPPORTED = 1'b1,
  parameter logic        IO_TRAP_SUPPORTED    = 1'b1,
  parameter logic [15:0] REVISION_NUMBER      = 16'h0001  // Arbitrary value
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Core events
  input  wire logic              smm_entry,
  input  wire entry_state_t      entry_state,
  input  wire logic              resume_req,
  input  wire logic              iret_done,
  input  wire logic              if_flag,
  input  wire logic              addr_bit20_mask,
  input  wire logic              debug_request,
  input  wire logic              stop_clock_request,
  input  wire logic              exception_req,
  // Core controls
  output logic                   in_smm_q,
  output logic                   intr_block_q,
  output logic                   nmi_block_q,
  output logic                   smi_block_q,
  output logic                   init_block_q,
  output logic                   addr20_force_q,
  output logic                   if_clear_q,
  output logic                   resume_halt_q,
  output logic                   resume_fetch_q,
  output logic                   debug_take_q,
  output logic                   stop_take_q,
  output logic                   exception_take_q,
  // Special cycles to the system
  output logic                   entry_cycle_q,
  output logic                   exit_cycle_q,
  output logic                   halt_cycle_q
);

  logic              wr_en, wr_hit, rd_hit;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0]       wr_data, rd_data;
  logic [3:0]        wr_strb;

  logic        halt_restart_q;
  logic        nmi_masked_record_q;
  logic [7:0]  virt_q;
  logic [31:0] base_copy_q;
  logic [31:0] handler_region_base_q;
  logic [31:0] range0_q, range1_q;
  logic [2:0]  ctrl_q;
  logic        nmi_saved_q, nmi_smm_en_q;
  logic        enter, leave, in_smm_d;
  logic [31:0] revision_word;

  assign enter    = smm_entry & ~in_smm_q;
  assign leave    = resume_req & in_smm_q;
  assign in_smm_d = enter | (in_smm_q & ~leave);

  assign revision_word = {14'h0000, BASE_RELOC_SUPPORTED, IO_TRAP_SUPPORTED,
                          REVISION_NUMBER};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : merge

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = a == byte_addr(IDX_HALT_RESTART) || a == byte_addr(IDX_NMI_RECORD) ||
             a == byte_addr(IDX_VIRT_STATE)   || a == byte_addr(IDX_REVISION)   ||
             a == byte_addr(IDX_BASE_COPY)    || a == byte_addr(IDX_CONTROL)    ||
             a == byte_addr(IDX_HANDLER_BASE) || a == byte_addr(IDX_RANGE0)     ||
             a == byte_addr(IDX_RANGE1)       || a == byte_addr(IDX_STATUS);
  endfunction : mapped

  function automatic logic wr_at(input logic [15:0] idx);
    wr_at = wr_en && wr_addr == byte_addr(idx);
  endfunction : wr_at

  axil_slave_port u_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit  (wr_hit),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  assign wr_hit = mapped(wr_addr);
  assign rd_hit = mapped(rd_addr);

  // Read mux
  always_comb begin
    rd_data = WORD_RESET;
    unique case (rd_addr)
      byte_addr(IDX_HALT_RESTART): rd_data[HALT_BIT] = halt_restart_q;
      byte_addr(IDX_NMI_RECORD):   rd_data[NMI_BIT]  = nmi_masked_record_q;
      byte_addr(IDX_VIRT_STATE):   rd_data[7:0]      = virt_q;
      byte_addr(IDX_REVISION):     rd_data           = revision_word;
      byte_addr(IDX_BASE_COPY):    rd_data           = base_copy_q;
      byte_addr(IDX_CONTROL):      rd_data[2:0]      = ctrl_q;
      byte_addr(IDX_HANDLER_BASE): rd_data           = handler_region_base_q;
      byte_addr(IDX_RANGE0):       rd_data           = range0_q;
      byte_addr(IDX_RANGE1):       rd_data           = range1_q;
      byte_addr(IDX_STATUS): begin
        rd_data[STAT_IN_SMM] = in_smm_q;
        rd_data[STAT_NMI_EN] = nmi_smm_en_q;
      end
      default: rd_data = WORD_RESET;
    endcase
  end

  // Save-state bytes; entry wins over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_restart_q      <= 1'b0;
      nmi_masked_record_q <= 1'b0;
      virt_q              <= VIRT_HOST;
      base_copy_q         <= WORD_RESET;
    end else if (enter) begin
      halt_restart_q      <= entry_state.halted;
      nmi_masked_record_q <= entry_state.nmi_masked;
      virt_q              <= !entry_state.guest ? VIRT_HOST :
                             entry_state.nested_paging ? VIRT_NESTED : VIRT_GUEST;
      base_copy_q         <= handler_region_base_q;
    end else begin
      if (wr_at(IDX_HALT_RESTART) && wr_strb[0]) begin
        halt_restart_q <= wr_data[HALT_BIT];
      end
      if (wr_at(IDX_NMI_RECORD) && wr_strb[0]) begin
        nmi_masked_record_q <= wr_data[NMI_BIT];
      end
    end
  end

  // Control, handler base and protected ranges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q                <= CTRL_RESET;
      handler_region_base_q <= WORD_RESET;
      range0_q              <= WORD_RESET;
      range1_q              <= WORD_RESET;
    end else begin
      if (wr_at(IDX_CONTROL) && wr_strb[0]) begin
        ctrl_q[CTRL_ENTRY_DIS] <= wr_data[CTRL_ENTRY_DIS];
        ctrl_q[CTRL_EXIT_DIS]  <= wr_data[CTRL_EXIT_DIS];
        ctrl_q[CTRL_LOCK]      <= ctrl_q[CTRL_LOCK] | wr_data[CTRL_LOCK];
      end
      if (wr_at(IDX_HANDLER_BASE)) begin
        handler_region_base_q <= merge(handler_region_base_q, wr_data, wr_strb);
      end
      if (wr_at(IDX_RANGE0) && !ctrl_q[CTRL_LOCK]) begin
        range0_q <= merge(range0_q, wr_data, wr_strb);
      end
      if (wr_at(IDX_RANGE1) && !ctrl_q[CTRL_LOCK]) begin
        range1_q <= merge(range1_q, wr_data, wr_strb);
      end
    end
  end

  // Mode and interrupt masking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_smm_q       <= 1'b0;
      intr_block_q   <= 1'b0;
      smi_block_q    <= 1'b0;
      init_block_q   <= 1'b0;
      addr20_force_q <= 1'b0;
      if_clear_q     <= 1'b0;
    end else begin
      in_smm_q       <= in_smm_d;
      smi_block_q    <= in_smm_d;
      init_block_q   <= in_smm_d;
      intr_block_q   <= in_smm_d & (enter | if_clear_q | ~if_flag);
      addr20_force_q <= addr_bit20_mask & ~in_smm_d;
      if_clear_q     <= enter;
    end
  end

  // NMI masking inside and across the mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_saved_q  <= 1'b0;
      nmi_smm_en_q <= 1'b0;
      nmi_block_q  <= 1'b0;
    end else if (enter) begin
      nmi_saved_q  <= entry_state.nmi_masked;
      nmi_smm_en_q <= 1'b0;
      nmi_block_q  <= 1'b1;
    end else if (leave) begin
      nmi_smm_en_q <= 1'b0;
      nmi_block_q  <= nmi_saved_q;
    end else if (in_smm_q && iret_done) begin
      nmi_smm_en_q <= 1'b1;
      nmi_block_q  <= 1'b0;
    end
  end

  // Resume path and special cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_halt_q  <= 1'b0;
      resume_fetch_q <= 1'b0;
      halt_cycle_q   <= 1'b0;
      entry_cycle_q  <= 1'b0;
      exit_cycle_q   <= 1'b0;
    end else begin
      resume_halt_q  <= leave & halt_restart_q;
      resume_fetch_q <= leave & ~halt_restart_q;
      halt_cycle_q   <= leave & halt_restart_q;
      entry_cycle_q  <= enter & ~ctrl_q[CTRL_ENTRY_DIS];
      exit_cycle_q   <= leave & ~ctrl_q[CTRL_EXIT_DIS];
    end
  end

  // Requests still honoured in the mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      debug_take_q     <= 1'b0;
      stop_take_q      <= 1'b0;
      exception_take_q <= 1'b0;
    end else begin
      debug_take_q     <= debug_request;
      stop_take_q      <= stop_clock_request;
      exception_take_q <= exception_req;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  halt_record_a: assert property (enter |=> halt_restart_q == $past(entry_state.halted))
    else $error("halt bit not recorded on entry");
  resume_halt_a: assert property (leave && halt_restart_q |=>
      resume_halt_q && halt_cycle_q && !resume_fetch_q && !in_smm_q)
    else $error("halt resume wrong");
  resume_fetch_a: assert property (leave && !halt_restart_q |=>
      resume_fetch_q && !halt_cycle_q && !resume_halt_q)
    else $error("fetch resume wrong");
  virt_code_a: assert property (enter |=>
      virt_q == (!$past(entry_state.guest) ? VIRT_HOST :
                 $past(entry_state.nested_paging) ? VIRT_NESTED : VIRT_GUEST))
    else $error("bad virtualization code");
  base_copy_a: assert property (enter |=> base_copy_q == $past(handler_region_base_q))
    else $error("handler base not copied");
  entry_mask_a: assert property ($rose(in_smm_q) |->
      smi_block_q && init_block_q && intr_block_q && nmi_block_q && if_clear_q)
    else $error("inputs not masked on entry");
  addr20_free_a: assert property (in_smm_q |-> !addr20_force_q)
    else $error("address bit 20 forced in mode");
  nmi_iret_a: assert property (in_smm_q && iret_done && !leave |=> !nmi_block_q)
    else $error("NMI not enabled after IRET");
  nmi_hold_a: assert property (in_smm_q && !nmi_block_q && !leave |=> !nmi_block_q)
    else $error("NMI re-masked inside mode");
  nmi_restore_a: assert property (leave |=> nmi_block_q == $past(nmi_saved_q))
    else $error("NMI masking not restored");
  cycles_a: assert property (enter |=> entry_cycle_q == !$past(ctrl_q[CTRL_ENTRY_DIS]))
    else $error("entry cycle wrong");
  lock_a: assert property (ctrl_q[CTRL_LOCK] |=> $stable(range0_q) && $stable(range1_q))
    else $error("locked range changed");
  debug_take_a: assert property (debug_request && in_smm_q |=> debug_take_q)
    else $error("debug request dropped");

  entry_c:     cover property (enter ##[1:20] leave);
  halt_back_c: cover property (leave && halt_restart_q);
  iret_c:      cover property (in_smm_q && iret_done ##1 in_smm_q && !nmi_block_q);

endmodule : smm_save_state
`default_nettype wire
